// *** logic/ppifms_pkg.sv ***
package ppifms_pkg;

    // ------------------------------------------------------------
    // Register indices on the management port
    // ------------------------------------------------------------
    localparam logic [4:0] IDX_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] IDX_SPECIAL_IND = 5'h1B;
    localparam logic [4:0] IDX_IRQ_FLAGS = 5'h1D;
    localparam logic [4:0] IDX_IRQ_MASK = 5'h1E;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SOFT_RESET_BIT = 15;
    localparam int XOVR_OVERRIDE_BIT = 15;
    localparam int XOVR_ENABLE_BIT = 14;
    localparam int XOVR_STATE_BIT = 13;
    localparam int SQE_OFF_BIT = 11;
    localparam int PLL_LOCK_BIT = 10;
    localparam int POLARITY_BIT = 4;
    localparam int FLAG_LO = 1;
    localparam int FLAG_HI = 7;
    localparam int FLAG_ENERGY = 7;
    localparam int FLAG_ANEG_DONE = 6;
    localparam int FLAG_REMOTE_FAULT = 5;
    localparam int FLAG_LINK_DOWN = 4;
    localparam int FLAG_PARTNER_ACK = 3;
    localparam int FLAG_PDET_FAULT = 2;
    localparam int FLAG_PAGE_RX = 1;

    // ------------------------------------------------------------
    // Masks and values after reset
    // ------------------------------------------------------------
    localparam logic [15:0] SPECIAL_WR_MASK = 16'hEC00;
    localparam logic [15:0] SPECIAL_RESET = 16'h0000;
    localparam logic [7:1] FLAGS_RESET = 7'h00;
    localparam logic [7:1] MASK_RESET = 7'h00;
    localparam logic [15:0] READ_ZERO = 16'h0000;

    // ------------------------------------------------------------
    // Crossover mode
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        XOVR_STRAIGHT = 3'h1,
        XOVR_CROSS = 3'h2,
        XOVR_AUTO = 3'h4
    } ppifms_xover_type;

endpackage

// *** logic/ppifms_irq_if.sv ***
`timescale 1ns/1ps
interface ppifms_irq_if;
    logic [7:1] cond;
    logic [7:1] mask;
    logic [7:1] w1c;
    logic read_clear;
    logic hard_clear;
    logic [7:1] flags;

    modport core (
        input cond,
        input mask,
        input w1c,
        input read_clear,
        input hard_clear,
        output flags
    );

    modport ctrl (
        output cond,
        output mask,
        output w1c,
        output read_clear,
        output hard_clear,
        input flags
    );
endinterface

// *** logic/ppifms_irq_core.sv ***
`timescale 1ns/1ps
module ppifms_irq_core (
    input wire logic mclk,
    input wire logic reset_n,
    ppifms_irq_if.core irq
);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n || irq.hard_clear);

    // ------------------------------------------------------------
    // Event edge detection and sticky flags
    // ------------------------------------------------------------
    logic [7:1] cond_prev_q;
    logic [7:1] flags_q;
    logic [7:1] rise;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cond_prev_q <= ppifms_pkg::FLAGS_RESET;
        end else begin
            cond_prev_q <= irq.cond;
        end
    end

    assign rise = irq.cond & ~cond_prev_q;

    genvar i;
    generate
        for (i = ppifms_pkg::FLAG_LO; i <= ppifms_pkg::FLAG_HI; i++) begin : g_flag
            // A new event survives a read or write-one clear in the same cycle, but not a hard clear
            always_ff @(posedge mclk) begin
                if (!reset_n || irq.hard_clear) begin
                    flags_q[i] <= 1'b0;
                end else if (rise[i] && irq.mask[i]) begin
                    flags_q[i] <= 1'b1;
                end else if (irq.read_clear || irq.w1c[i]) begin
                    flags_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign irq.flags = flags_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_flag_latch_set: assert property ((rise & irq.mask) != 7'h00 |=>
        (flags_q & $past(rise & irq.mask)) == $past(rise & irq.mask))
        else $error("enabled event did not latch its flag");

    chk_mask_blocks_src: assert property (1'b1 |=>
        (flags_q & ~$past(flags_q) & ~$past(irq.mask)) == 7'h00)
        else $error("masked source latched a flag");

    chk_read_clears_all: assert property (irq.read_clear && (rise & irq.mask) == 7'h00
        |=> flags_q == 7'h00)
        else $error("read did not clear the flags");

endmodule

// *** logic/ppifms_top.sv ***
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module ppifms_top (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wr_data,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    output logic [15:0] reg_rd_data,
    input wire logic port_phy_reset,
    input wire logic energy_detected,
    input wire logic autoneg_complete,
    input wire logic remote_fault,
    input wire logic link_up,
    input wire logic partner_ack,
    input wire logic parallel_detect_fault,
    input wire logic page_received,
    input wire logic polarity_reversed_in,
    input wire logic manual_mdix_strap,
    input wire logic auto_mdix_strap,
    output logic rx_pll_ref_lock,
    output logic sqe_test_disable,
    output logic mdix_auto,
    output logic mdix_cross,
    output logic soft_reset_pulse,
    output logic phy_irq
);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    logic wr_basic;
    logic wr_special;
    logic wr_flags;
    logic wr_mask;
    logic rd_flags;

    assign wr_basic = reg_wr_en && (reg_addr == ppifms_pkg::IDX_BASIC_CONTROL);
    assign wr_special = reg_wr_en && (reg_addr == ppifms_pkg::IDX_SPECIAL_IND);
    assign wr_flags = reg_wr_en && (reg_addr == ppifms_pkg::IDX_IRQ_FLAGS);
    assign wr_mask = reg_wr_en && (reg_addr == ppifms_pkg::IDX_IRQ_MASK);
    assign rd_flags = reg_rd_en && (reg_addr == ppifms_pkg::IDX_IRQ_FLAGS);

    // ------------------------------------------------------------
    // Reset scopes
    // ------------------------------------------------------------
    logic hard_rst;
    logic soft_rst_q;

    // Port PHY reset reaches every bit, soft reset only the ordinary ones
    assign hard_rst = !reset_n || port_phy_reset;

    always_ff @(posedge mclk) begin
        if (hard_rst) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= wr_basic && reg_wr_data[ppifms_pkg::SOFT_RESET_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= soft_rst_q;
        end
    end

    // ------------------------------------------------------------
    // Special control / indication register
    // ------------------------------------------------------------
    logic [15:0] special_q;
    logic pol_q;

    always_ff @(posedge mclk) begin
        if (hard_rst) begin
            special_q <= ppifms_pkg::SPECIAL_RESET;
        end else if (wr_special) begin
            special_q <= reg_wr_data & ppifms_pkg::SPECIAL_WR_MASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (hard_rst) begin
            pol_q <= 1'b0;
        end else begin
            pol_q <= polarity_reversed_in;
        end
    end

    always_ff @(posedge mclk) begin
        if (hard_rst) begin
            rx_pll_ref_lock <= 1'b0;
            sqe_test_disable <= 1'b0;
        end else begin
            rx_pll_ref_lock <= special_q[ppifms_pkg::PLL_LOCK_BIT];
            sqe_test_disable <= special_q[ppifms_pkg::SQE_OFF_BIT];
        end
    end

    // ------------------------------------------------------------
    // Strap synchronisers
    // ------------------------------------------------------------
    logic [1:0] strap_s1_q;
    logic [1:0] strap_s2_q;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            strap_s1_q <= 2'h0;
            strap_s2_q <= 2'h0;
        end else begin
            strap_s1_q <= {auto_mdix_strap, manual_mdix_strap};
            strap_s2_q <= strap_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Crossover mode
    // ------------------------------------------------------------
    ppifms_pkg::ppifms_xover_type xover_q;
    ppifms_pkg::ppifms_xover_type xover_d;

    always_comb begin
        xover_d = xover_q;
        if (special_q[ppifms_pkg::XOVR_OVERRIDE_BIT]) begin
            case ({special_q[ppifms_pkg::XOVR_ENABLE_BIT], special_q[ppifms_pkg::XOVR_STATE_BIT]})
                2'h0: xover_d = ppifms_pkg::XOVR_STRAIGHT;
                2'h1: xover_d = ppifms_pkg::XOVR_CROSS;
                2'h2: xover_d = ppifms_pkg::XOVR_AUTO;
                default: xover_d = xover_q;
            endcase
        end else if (strap_s2_q[1]) begin
            xover_d = ppifms_pkg::XOVR_AUTO;
        end else if (strap_s2_q[0]) begin
            xover_d = ppifms_pkg::XOVR_CROSS;
        end else begin
            xover_d = ppifms_pkg::XOVR_STRAIGHT;
        end
    end

    always_ff @(posedge mclk) begin
        if (hard_rst) begin
            xover_q <= ppifms_pkg::XOVR_STRAIGHT;
        end else begin
            xover_q <= xover_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (hard_rst) begin
            mdix_auto <= 1'b0;
            mdix_cross <= 1'b0;
        end else begin
            mdix_auto <= (xover_d == ppifms_pkg::XOVR_AUTO);
            mdix_cross <= (xover_d == ppifms_pkg::XOVR_CROSS);
        end
    end

    // ------------------------------------------------------------
    // Interrupt mask and flags
    // ------------------------------------------------------------
    logic [7:1] mask_q;
    ppifms_irq_if irq_bus ();

    always_ff @(posedge mclk) begin
        if (hard_rst || soft_rst_q) begin
            mask_q <= ppifms_pkg::MASK_RESET;
        end else if (wr_mask) begin
            mask_q <= reg_wr_data[7:1];
        end
    end

    assign irq_bus.cond[ppifms_pkg::FLAG_ENERGY] = energy_detected;
    assign irq_bus.cond[ppifms_pkg::FLAG_ANEG_DONE] = autoneg_complete;
    assign irq_bus.cond[ppifms_pkg::FLAG_REMOTE_FAULT] = remote_fault;
    assign irq_bus.cond[ppifms_pkg::FLAG_LINK_DOWN] = !link_up;
    assign irq_bus.cond[ppifms_pkg::FLAG_PARTNER_ACK] = partner_ack;
    assign irq_bus.cond[ppifms_pkg::FLAG_PDET_FAULT] = parallel_detect_fault;
    assign irq_bus.cond[ppifms_pkg::FLAG_PAGE_RX] = page_received;
    assign irq_bus.mask = mask_q;
    assign irq_bus.w1c = wr_flags ? reg_wr_data[7:1] : 7'h00;
    assign irq_bus.read_clear = rd_flags;
    assign irq_bus.hard_clear = port_phy_reset || soft_rst_q;

    ppifms_irq_core u_irq_core (
        .mclk(mclk),
        .reset_n(reset_n),
        .irq(irq_bus)
    );

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            phy_irq <= 1'b0;
        end else begin
            phy_irq <= |(irq_bus.flags & mask_q);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [15:0] rd_d;

    always_comb begin
        rd_d = ppifms_pkg::READ_ZERO;
        if (reg_rd_en) begin
            case (reg_addr)
                ppifms_pkg::IDX_BASIC_CONTROL: begin
                    rd_d[ppifms_pkg::SOFT_RESET_BIT] = soft_rst_q;
                end
                ppifms_pkg::IDX_SPECIAL_IND: begin
                    rd_d = special_q;
                    rd_d[ppifms_pkg::POLARITY_BIT] = pol_q;
                end
                ppifms_pkg::IDX_IRQ_FLAGS: begin
                    rd_d[7:1] = irq_bus.flags;
                end
                ppifms_pkg::IDX_IRQ_MASK: begin
                    rd_d[7:1] = mask_q;
                end
                default: begin
                    rd_d = ppifms_pkg::READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            reg_rd_data <= ppifms_pkg::READ_ZERO;
        end else begin
            reg_rd_data <= rd_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_pll_lock_follows: assert property (disable iff (!reset_n || port_phy_reset)
        wr_special ##1 !port_phy_reset |=> rx_pll_ref_lock == $past(reg_wr_data[10], 2))
        else $error("pll lock output does not follow written bit");

    chk_polarity_read: assert property (reg_rd_en && reg_addr == 5'h1B |=>
        reg_rd_data[4] == $past(pol_q))
        else $error("polarity bit reads wrong");

    chk_reserved_zero: assert property (reg_rd_en && reg_addr == 5'h1B |=>
        reg_rd_data[9:5] == 5'h00 && reg_rd_data[3:0] == 4'h0 && reg_rd_data[12] == 1'b0)
        else $error("reserved special bits read nonzero");

    chk_soft_keeps_bits: assert property (soft_rst_q && !port_phy_reset && !wr_special
        |=> special_q == $past(special_q))
        else $error("soft reset disturbed protected bits");

    chk_port_reset_clears: assert property (port_phy_reset |=>
        special_q == 16'h0000 && mask_q == 7'h00 && !rx_pll_ref_lock ##1 !rx_pll_ref_lock)
        else $error("port reset did not clear protected bits");

    chk_xover_manual_cross: assert property (special_q[15] && !special_q[14]
        && special_q[13] && !port_phy_reset |=> mdix_cross && !mdix_auto)
        else $error("manual crossover not selected");

    chk_xover_auto_sel: assert property (special_q[15] && special_q[14] && !special_q[13]
        && !port_phy_reset |=> mdix_auto && !mdix_cross)
        else $error("automatic crossover not selected");

    chk_strap_control: assert property (!special_q[15] && strap_s2_q == 2'h0
        && !port_phy_reset |=> !mdix_auto && !mdix_cross)
        else $error("straps not followed without override");

    chk_link_down_flag: assert property (link_up && mask_q[4]
        && !port_phy_reset && !soft_rst_q
        ##1 !link_up && mask_q[4] && !port_phy_reset && !soft_rst_q |=> irq_bus.flags[4])
        else $error("link down did not latch flag");

    chk_irq_level: assert property (1'b1 |=> phy_irq == $past(|(irq_bus.flags & mask_q)))
        else $error("interrupt output wrong");

    chk_flags_read_back: assert property (rd_flags |=>
        reg_rd_data == {8'h00, $past(irq_bus.flags), 1'b0})
        else $error("flags read value wrong");

    chk_energy_flag: assert property (!energy_detected ##1 energy_detected && mask_q[7]
        && !irq_bus.hard_clear |=> irq_bus.flags[7])
        else $error("energy event did not latch flag");

    chk_aneg_flag: assert property (!autoneg_complete ##1 autoneg_complete && mask_q[6]
        && !irq_bus.hard_clear |=> irq_bus.flags[6])
        else $error("autonegotiation done did not latch flag");

    chk_remote_flag: assert property (!remote_fault ##1 remote_fault && mask_q[5]
        && !irq_bus.hard_clear |=> irq_bus.flags[5])
        else $error("remote fault did not latch flag");

    chk_ack_flag: assert property (!partner_ack ##1 partner_ack && mask_q[3]
        && !irq_bus.hard_clear |=> irq_bus.flags[3])
        else $error("partner acknowledge did not latch flag");

    chk_pdet_flag: assert property (!parallel_detect_fault ##1
        parallel_detect_fault && mask_q[2] && !irq_bus.hard_clear |=> irq_bus.flags[2])
        else $error("parallel detection fault did not latch flag");

    chk_page_flag: assert property (!page_received ##1 page_received && mask_q[1]
        && !irq_bus.hard_clear |=> irq_bus.flags[1])
        else $error("page received did not latch flag");

    chk_soft_clears_irq: assert property (soft_rst_q |=>
        mask_q == 7'h00 && irq_bus.flags == 7'h00)
        else $error("soft reset did not clear mask and flags");

    chk_xover_straight: assert property (special_q[15] && !special_q[14] && !special_q[13]
        && !port_phy_reset |=> !mdix_auto && !mdix_cross)
        else $error("manual straight mode not selected");

    chk_polarity_capture: assert property (!port_phy_reset |=>
        pol_q == $past(polarity_reversed_in))
        else $error("polarity state not captured");

    chk_strap_auto: assert property (!special_q[15] && strap_s2_q[1]
        && !port_phy_reset |=> mdix_auto && !mdix_cross)
        else $error("auto strap not followed");

    chk_strap_manual: assert property (!special_q[15] && strap_s2_q == 2'h1
        && !port_phy_reset |=> mdix_cross && !mdix_auto)
        else $error("manual strap not followed");

endmodule

// *** bench/ppifms_tb_top.sv ***
`timescale 1ns/1ps
module ppifms_tb_top;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wr_data = 16'h0000;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [15:0] reg_rd_data;
    logic port_phy_reset = 1'b0;
    logic [7:1] ev = 7'h00;
    logic pol_in = 1'b0;
    logic man_strap = 1'b0;
    logic auto_strap = 1'b0;
    logic rx_pll_ref_lock, sqe_test_disable, mdix_auto, mdix_cross, soft_reset_pulse, phy_irq;
    logic rd_d = 1'b0;
    logic pulse_seen = 1'b0;
    logic [15:0] exp_q[$];
    logic [15:0] mode_wr [3] = '{16'h8000, 16'hA400, 16'hC000};
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;

    always #10 mclk = ~mclk;

    // Event bit 4 is the link going down, so the link level is its inverse
    ppifms_top DUT (
        .mclk(mclk),
        .reset_n(reset_n),
        .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data),
        .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data),
        .port_phy_reset(port_phy_reset),
        .energy_detected(ev[7]),
        .autoneg_complete(ev[6]),
        .remote_fault(ev[5]),
        .link_up(~ev[4]),
        .partner_ack(ev[3]),
        .parallel_detect_fault(ev[2]),
        .page_received(ev[1]),
        .polarity_reversed_in(pol_in),
        .manual_mdix_strap(man_strap),
        .auto_mdix_strap(auto_strap),
        .rx_pll_ref_lock(rx_pll_ref_lock),
        .sqe_test_disable(sqe_test_disable),
        .mdix_auto(mdix_auto),
        .mdix_cross(mdix_cross),
        .soft_reset_pulse(soft_reset_pulse),
        .phy_irq(phy_irq)
    );

    // ------------------------------------------------------------
    // Compare and bus tasks
    // ------------------------------------------------------------
    task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk1(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge mclk);
        reg_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        exp_q.push_back(e);
        @(posedge mclk);
        reg_rd_en <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic stop_test();
        if (n_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Output watcher: read data stands only in the cycle after a read
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        rd_d <= reg_rd_en;
        if (soft_reset_pulse === 1'b1) begin
            pulse_seen <= 1'b1;
        end
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            stop_test();
        end
    end

    always @(negedge mclk) begin
        if (rd_d && exp_q.size() != 0) begin
            chk16("reg_rd_data", exp_q.pop_front(), reg_rd_data);
        end else if (reset_n) begin
            chk16("idle_rd_data", 16'h0000, reg_rd_data);
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [6:0] m;
        logic [6:0] r;
        void'($urandom(32'h761D));
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        rd(ppifms_pkg::IDX_SPECIAL_IND, 16'h0000);
        rd(ppifms_pkg::IDX_IRQ_FLAGS, 16'h0000);
        rd(ppifms_pkg::IDX_IRQ_MASK, 16'h0000);
        rd(5'h05, 16'h0000);
        #1;
        chk1("phy_irq", 1'b0, phy_irq);
        // Override modes; enable and state are never both written high
        for (int i = 0; i < 3; i++) begin
            wr(ppifms_pkg::IDX_SPECIAL_IND, mode_wr[i] | 16'h13EF);
            rd(ppifms_pkg::IDX_SPECIAL_IND, mode_wr[i]);
            idle(2);
            chk1("mdix_auto", mode_wr[i][14], mdix_auto);
            chk1("mdix_cross", mode_wr[i][13], mdix_cross);
            chk1("rx_pll_ref_lock", mode_wr[i][10], rx_pll_ref_lock);
        end
        wr(ppifms_pkg::IDX_SPECIAL_IND, 16'h0000);
        for (int s = 0; s < 4; s++) begin
            @(posedge mclk);
            {auto_strap, man_strap} <= 2'(s);
            idle(6);
            chk1("mdix_auto", auto_strap, mdix_auto);
            chk1("mdix_cross", man_strap & ~auto_strap, mdix_cross);
        end
        @(posedge mclk);
        pol_in <= 1'b1;
        idle(2);
        rd(ppifms_pkg::IDX_SPECIAL_IND, 16'h0010);
        @(posedge mclk);
        pol_in <= 1'b0;
        wr(ppifms_pkg::IDX_SPECIAL_IND, 16'h0010);
        idle(2);
        rd(ppifms_pkg::IDX_SPECIAL_IND, 16'h0000);
        // Each source alone, then random masks against random event sets
        for (int n = 0; n < 16; n++) begin
            m = (n < 7) ? 7'h7F : 7'($urandom);
            r = (n < 7) ? 7'(1 << n) : 7'($urandom);
            wr(ppifms_pkg::IDX_IRQ_MASK, {8'hFF, m, 1'b1});
            rd(ppifms_pkg::IDX_IRQ_MASK, {8'h00, m, 1'b0});
            @(posedge mclk);
            ev <= r;
            idle(3);
            chk1("phy_irq", |(r & m), phy_irq);
            rd(ppifms_pkg::IDX_IRQ_FLAGS, {8'h00, r & m, 1'b0});
            rd(ppifms_pkg::IDX_IRQ_FLAGS, 16'h0000);
            @(posedge mclk);
            ev <= 7'h00;
            idle(2);
            chk1("phy_irq", 1'b0, phy_irq);
        end
        // Writing a one clears only that flag
        wr(ppifms_pkg::IDX_IRQ_MASK, 16'h00FE);
        @(posedge mclk);
        ev <= 7'h03;
        idle(3);
        wr(ppifms_pkg::IDX_IRQ_FLAGS, 16'h0002);
        rd(ppifms_pkg::IDX_IRQ_FLAGS, 16'h0004);
        rd(ppifms_pkg::IDX_IRQ_FLAGS, 16'h0000);
        @(posedge mclk);
        ev <= 7'h00;
        idle(2);
        // Soft reset keeps protected bits, port reset clears them
        wr(ppifms_pkg::IDX_SPECIAL_IND, 16'hAC00);
        wr(ppifms_pkg::IDX_IRQ_MASK, 16'h00FE);
        @(posedge mclk);
        ev <= 7'h20;
        idle(3);
        wr(ppifms_pkg::IDX_BASIC_CONTROL, 16'h8000);
        idle(3);
        chk1("soft_reset_pulse", 1'b1, pulse_seen);
        chk1("phy_irq", 1'b0, phy_irq);
        rd(ppifms_pkg::IDX_SPECIAL_IND, 16'hAC00);
        rd(ppifms_pkg::IDX_IRQ_MASK, 16'h0000);
        rd(ppifms_pkg::IDX_IRQ_FLAGS, 16'h0000);
        #1;
        chk1("rx_pll_ref_lock", 1'b1, rx_pll_ref_lock);
        chk1("sqe_test_disable", 1'b1, sqe_test_disable);
        @(posedge mclk);
        port_phy_reset <= 1'b1;
        @(posedge mclk);
        port_phy_reset <= 1'b0;
        idle(3);
        rd(ppifms_pkg::IDX_SPECIAL_IND, 16'h0000);
        #1;
        chk1("rx_pll_ref_lock", 1'b0, rx_pll_ref_lock);
        chk1("sqe_test_disable", 1'b0, sqe_test_disable);
        idle(3);
        stop_test();
    end

endmodule
